// ### rtl/ccp_config_parser.v
`timescale 1ns/10ps
`include "ccp_regs.vh"
// Operation
// - option 04h bit2 disables chained writes
// - option 05h ten bytes, bit1 enables crypto
// - option 06h accepts 17 or 19 bytes
// - rename bits 4..0 name length 1-16
// - identifiers LSB first, four reserved values
// - option 08h accepts 3, 5, 9 bytes
// - rename bit1 two files, bit0 identifiers
// - first identifier present only when bit0
// - second file numbers present only when bit1
// - second identifier only when both bits
// - option 09h takes fourteen value bytes
// - signed limits, floor not above ceiling
// - current value within floor and ceiling
// - value option bit1 free read, bit0 credit
// - option 0Ah five bytes, bit0 enables counter
// - counter limit above zero, defaults, LSB first
// - wrong length answers 7Eh
// - repeated one-time option answers 9Dh
// - unknown file number answers F0h
module ccp_config_parser (
	input wire i_clk,
	input wire i_resetn,
	input wire i_cmd_valid,
	input wire [7:0] i_cmd_option,
	input wire [4:0] i_cmd_len,
	input wire i_byte_valid,
	input wire [7:0] i_byte,
	input wire [31:0] i_file_present,
	input wire [31:0] i_file_is_value,
	input wire i_store_done,
	output reg o_busy,
	output reg o_resp_valid,
	output reg [7:0] o_resp_status,
	output reg o_store_req,
	output reg o_no_chain_write,
	output reg o_leak_resilient_crypto_mode,
	output reg [7:0] o_user_capability_5,
	output reg [7:0] o_user_capability_6,
	output reg [7:0] o_app_rename_option_byte,
	output reg [127:0] o_directory_name,
	output reg [15:0] o_app_iso_file_identifier,
	output reg [4:0] o_first_current_file_number,
	output reg [4:0] o_first_new_file_number,
	output reg [15:0] o_first_new_iso_identifier,
	output reg [4:0] o_second_current_file_number,
	output reg [4:0] o_second_new_file_number,
	output reg [15:0] o_second_new_iso_identifier,
	output reg o_rename_two,
	output reg o_rename_iso,
	output reg [4:0] o_value_file_number,
	output reg [31:0] o_value_floor,
	output reg [31:0] o_value_ceiling,
	output reg [31:0] o_value_current,
	output reg o_value_free_read,
	output reg o_bounded_credit_enable,
	output reg o_fail_counter_enable,
	output reg [15:0] o_fail_counter_limit,
	output reg [15:0] o_fail_counter_decrement,
	output reg o_app_rename_done,
	output reg o_file_rename_done,
	output reg o_value_setup_done
);
	// one-hot states
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_COLLECT = 4'b0010;
	localparam [3:0] ST_CHECK = 4'b0100;
	localparam [3:0] ST_STORE = 4'b1000;
	reg [3:0] state_reg;
	// collected data field
	reg [7:0] buf_mem [0:`CCP_MAX_BYTES-1];
	reg [4:0] cnt_reg;
	reg [4:0] len_reg;
	reg [7:0] opt_reg;
	// pending status and apply decision
	reg [7:0] status_next;
	reg value_ok_hold;
	wire value_ok;
	integer k;
	// reserved identifiers may never be assigned
	function fid_bad;
		input [15:0] f;
		begin
			fid_bad = (f == `CCP_FID_RES0) || (f == `CCP_FID_RES1) ||
				(f == `CCP_FID_RES2) || (f == `CCP_FID_RES3);
		end
	endfunction
	// assemble a little-endian 16-bit word from the buffer
	function [15:0] le16;
		input [7:0] lo;
		input [7:0] hi;
		begin
			le16 = {hi, lo};
		end
	endfunction
	// field views, byte 0 is the option byte of the rename and counter fields and the file number in the 09h field
	wire [7:0] b0 = buf_mem[0];
	wire fr_two = b0[`CCP_BIT_FR_TWO];
	wire fr_iso = b0[`CCP_BIT_FR_ISO];
	// first identifier follows the two file numbers
	wire [15:0] fr_fid1 = le16(buf_mem[3], buf_mem[4]);
	// second file numbers shift by two when identifier present
	wire [7:0] fr_old2 = fr_iso ? buf_mem[5] : buf_mem[3];
	wire [7:0] fr_new2 = fr_iso ? buf_mem[6] : buf_mem[4];
	// second identifier only with both bits
	wire [15:0] fr_fid2 = le16(buf_mem[7], buf_mem[8]);
	wire [31:0] v_floor = {buf_mem[4], buf_mem[3], buf_mem[2], buf_mem[1]};
	wire [31:0] v_ceil = {buf_mem[8], buf_mem[7], buf_mem[6], buf_mem[5]};
	wire [31:0] v_cur = {buf_mem[12], buf_mem[11], buf_mem[10], buf_mem[9]};
	wire [15:0] app_fid = le16(buf_mem[`CCP_POS_APP_FID], buf_mem[`CCP_POS_APP_FID+1]);
	wire [15:0] fc_limit = le16(buf_mem[1], buf_mem[2]);
	wire [15:0] fc_decr = le16(buf_mem[3], buf_mem[4]);
	wire [4:0] name_len = b0[`CCP_APP_LEN_HI:0];
	// signed range check lives in the leaf
	ccp_value_check u_vchk (
		.i_floor(v_floor),
		.i_ceiling(v_ceil),
		.i_value(v_cur),
		.o_ok(value_ok)
	);
	// expected rename length from option bits
	wire [4:0] fr_len = fr_two ? (fr_iso ? `CCP_LEN_FR_3 : `CCP_LEN_FR_2) : (fr_iso ? `CCP_LEN_FR_2 : `CCP_LEN_FR_1);

	// status decision; order is length, permission, file, file type, parameter
	always @* begin
		status_next = `CCP_ST_OK;
		case (opt_reg)
			`CCP_OPT_SM: begin
				if (len_reg != `CCP_LEN_SM) status_next = `CCP_ST_LENGTH;
			end
			`CCP_OPT_CAP: begin
				if (len_reg != `CCP_LEN_CAP) status_next = `CCP_ST_LENGTH;
			end
			`CCP_OPT_APPREN: begin
				if (len_reg != `CCP_LEN_APP_A && len_reg != `CCP_LEN_APP_B) status_next = `CCP_ST_LENGTH;
				else if (o_app_rename_done) status_next = `CCP_ST_DENIED;
				else if (name_len == 5'h00 || name_len > `CCP_DIRNAME_MAX) status_next = `CCP_ST_PARAM;
				// reserved identifier, only when 19 bytes carry one
				else if (len_reg == `CCP_LEN_APP_B && fid_bad(app_fid)) status_next = `CCP_ST_PARAM;
			end
			`CCP_OPT_FILEREN: begin
				if (len_reg != fr_len) status_next = `CCP_ST_LENGTH;
				else if (o_file_rename_done) status_next = `CCP_ST_DENIED;
				else if (!i_file_present[buf_mem[1][4:0]] || (fr_two && !i_file_present[fr_old2[4:0]]))
					status_next = `CCP_ST_NOFILE;
				else if (fr_iso && (fid_bad(fr_fid1) || (fr_two && fid_bad(fr_fid2))))
					status_next = `CCP_ST_PARAM;
			end
			`CCP_OPT_VALUE: begin
				if (len_reg != `CCP_LEN_VALUE) status_next = `CCP_ST_LENGTH;
				else if (o_value_setup_done) status_next = `CCP_ST_DENIED;
				else if (!i_file_present[b0[4:0]]) status_next = `CCP_ST_NOFILE;
				else if (!i_file_is_value[b0[4:0]]) status_next = `CCP_ST_DENIED;
				else if (!value_ok_hold) status_next = `CCP_ST_PARAM;
			end
			`CCP_OPT_FAILCTR: begin
				if (len_reg != `CCP_LEN_FAILCTR) status_next = `CCP_ST_LENGTH;
				else if (b0[`CCP_BIT_FC_EN] && fc_limit == `CCP_ZERO16) status_next = `CCP_ST_PARAM;
			end
			default: status_next = `CCP_ST_PARAM;
		endcase
	end

	// main sequencer
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 5'h00;
			len_reg <= 5'h00;
			opt_reg <= 8'h00;
			value_ok_hold <= 1'b0;
			o_busy <= 1'b0;
			o_resp_valid <= 1'b0;
			o_resp_status <= `CCP_ST_OK;
			o_store_req <= 1'b0;
			o_no_chain_write <= 1'b0;
			o_leak_resilient_crypto_mode <= 1'b0;
			o_user_capability_5 <= 8'h00;
			o_user_capability_6 <= 8'h00;
			o_app_rename_option_byte <= 8'h00;
			o_directory_name <= 128'h0;
			o_app_iso_file_identifier <= 16'h0000;
			o_first_current_file_number <= 5'h00;
			o_first_new_file_number <= 5'h00;
			o_first_new_iso_identifier <= 16'h0000;
			o_second_current_file_number <= 5'h00;
			o_second_new_file_number <= 5'h00;
			o_second_new_iso_identifier <= 16'h0000;
			o_rename_two <= 1'b0;
			o_rename_iso <= 1'b0;
			o_value_file_number <= 5'h00;
			o_value_floor <= 32'h0000_0000;
			o_value_ceiling <= 32'h0000_0000;
			o_value_current <= 32'h0000_0000;
			o_value_free_read <= 1'b0;
			o_bounded_credit_enable <= 1'b0;
			o_fail_counter_enable <= 1'b1;
			o_fail_counter_limit <= `CCP_FC_LIMIT_DEF;
			o_fail_counter_decrement <= `CCP_FC_DECR_DEF;
			o_app_rename_done <= 1'b0;
			o_file_rename_done <= 1'b0;
			o_value_setup_done <= 1'b0;
		end else begin
			o_resp_valid <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					// a command opens the data collection
					if (i_cmd_valid) begin
						opt_reg <= i_cmd_option;
						len_reg <= i_cmd_len;
						cnt_reg <= 5'h00;
						value_ok_hold <= 1'b0; // no stale range verdict from an earlier field
						o_busy <= 1'b1;
						state_reg <= (i_cmd_len == 5'h00) ? ST_CHECK : ST_COLLECT;
					end
				end
				ST_COLLECT: begin
					// bytes beyond the buffer are dropped, length still judged
					if (i_byte_valid) begin
						cnt_reg <= cnt_reg + 5'h01;
						if (cnt_reg + 5'h01 == len_reg) state_reg <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					value_ok_hold <= value_ok;
					// one extra cycle keeps the signed compare off the decision path
					if (opt_reg == `CCP_OPT_VALUE && !value_ok_hold && value_ok) begin
						state_reg <= ST_CHECK;
					end else if (status_next != `CCP_ST_OK) begin
						o_resp_status <= status_next;
						o_resp_valid <= 1'b1;
						o_busy <= 1'b0;
						state_reg <= ST_IDLE;
					end else begin
						// ask the store first, settings follow the acknowledge
						o_store_req <= 1'b1;
						state_reg <= ST_STORE;
					end
				end
				ST_STORE: begin
					if (i_store_done) begin
						o_store_req <= 1'b0;
						o_busy <= 1'b0;
						o_resp_valid <= 1'b1;
						o_resp_status <= `CCP_ST_OK;
						state_reg <= ST_IDLE;
						case (opt_reg)
							`CCP_OPT_SM: begin
								// only a one sets the lock, zero is no change
								if (buf_mem[1][`CCP_BIT_SM_NOCHAIN]) o_no_chain_write <= 1'b1;
							end
							`CCP_OPT_CAP: begin
								if (buf_mem[`CCP_POS_CAP_USER1][`CCP_BIT_CAP_LRC]) o_leak_resilient_crypto_mode <= 1'b1;
								o_user_capability_5 <= buf_mem[`CCP_POS_CAP_USER5];
								o_user_capability_6 <= buf_mem[`CCP_POS_CAP_USER6];
							end
							`CCP_OPT_APPREN: begin
								o_app_rename_option_byte <= b0;
								// name taken whole as padded by the reader
								for (k = 0; k < 16; k = k + 1) begin
									o_directory_name[8*k +: 8] <= buf_mem[`CCP_POS_DIRNAME + k];
								end
								// identifier only when bit7 asks for it
								if (b0[`CCP_BIT_APP_ISO] && len_reg == `CCP_LEN_APP_B) o_app_iso_file_identifier <= app_fid;
								o_app_rename_done <= 1'b1;
							end
							`CCP_OPT_FILEREN: begin
								o_rename_two <= fr_two;
								o_rename_iso <= fr_iso;
								o_first_current_file_number <= buf_mem[1][4:0];
								o_first_new_file_number <= buf_mem[2][4:0];
								if (fr_iso) o_first_new_iso_identifier <= fr_fid1;
								if (fr_two) begin
									o_second_current_file_number <= fr_old2[4:0];
									o_second_new_file_number <= fr_new2[4:0];
								end
								if (fr_two && fr_iso) o_second_new_iso_identifier <= fr_fid2;
								o_file_rename_done <= 1'b1;
							end
							`CCP_OPT_VALUE: begin
								o_value_file_number <= b0[4:0];
								o_value_floor <= v_floor;
								o_value_ceiling <= v_ceil;
								o_value_current <= v_cur;
								o_value_free_read <= buf_mem[13][`CCP_BIT_VO_FREE];
								o_bounded_credit_enable <= buf_mem[13][`CCP_BIT_VO_LIMCR];
								o_value_setup_done <= 1'b1;
							end
							`CCP_OPT_FAILCTR: begin
								o_fail_counter_enable <= b0[`CCP_BIT_FC_EN];
								// limit and decrement ignored when disabling
								if (b0[`CCP_BIT_FC_EN]) begin
									o_fail_counter_limit <= fc_limit;
									o_fail_counter_decrement <= fc_decr;
								end
							end
							default: o_busy <= 1'b0;
						endcase
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// data buffer has no reset; stale bytes are never applied without a full field
	always @(posedge i_clk) begin
		if (state_reg == ST_COLLECT && i_byte_valid && cnt_reg < `CCP_MAX_BYTES) begin
			buf_mem[cnt_reg] <= i_byte;
		end
	end
endmodule

// ### shared/ccp_regs.vh
`ifndef CCP_REGS_VH
`define CCP_REGS_VH
// option codes
`define CCP_OPT_SM 8'h04
`define CCP_OPT_CAP 8'h05
`define CCP_OPT_APPREN 8'h06
`define CCP_OPT_FILEREN 8'h08
`define CCP_OPT_VALUE 8'h09
`define CCP_OPT_FAILCTR 8'h0A
// data lengths in bytes
`define CCP_LEN_SM 5'h02
`define CCP_LEN_CAP 5'h0A
`define CCP_LEN_APP_A 5'h11
`define CCP_LEN_APP_B 5'h13
`define CCP_LEN_FR_1 5'h03
`define CCP_LEN_FR_2 5'h05
`define CCP_LEN_FR_3 5'h09
`define CCP_LEN_VALUE 5'h0E
`define CCP_LEN_FAILCTR 5'h05
`define CCP_MAX_BYTES 20
`define CCP_IDX_W 5
// byte positions inside the data field
`define CCP_POS_CAP_USER1 5'h04
`define CCP_POS_CAP_USER5 5'h08
`define CCP_POS_CAP_USER6 5'h09
`define CCP_POS_APP_FID 5'h11
`define CCP_POS_DIRNAME 5'h01
// bit positions
`define CCP_BIT_SM_NOCHAIN 2
`define CCP_BIT_CAP_LRC 1
`define CCP_BIT_APP_ISO 7
`define CCP_BIT_FR_TWO 1
`define CCP_BIT_FR_ISO 0
`define CCP_BIT_VO_FREE 1
`define CCP_BIT_VO_LIMCR 0
`define CCP_BIT_FC_EN 0
`define CCP_APP_LEN_HI 4
`define CCP_DIRNAME_MAX 5'h10
// status codes
`define CCP_ST_OK 8'h00
`define CCP_ST_LENGTH 8'h7E
`define CCP_ST_PARAM 8'h9E
`define CCP_ST_DENIED 8'h9D
`define CCP_ST_NOFILE 8'hF0
// reserved identifiers
`define CCP_FID_RES0 16'h0000
`define CCP_FID_RES1 16'h3F00
`define CCP_FID_RES2 16'h3FFF
`define CCP_FID_RES3 16'hFFFF
// counter defaults
`define CCP_FC_LIMIT_DEF 16'h03E8
`define CCP_FC_DECR_DEF 16'h000A
`define CCP_ZERO16 16'h0000
`endif

// ### rtl/ccp_value_check.v
`timescale 1ns/10ps
`include "ccp_regs.vh"
// signed range check for value file setup, purely combinational
module ccp_value_check (
	input wire [31:0] i_floor,
	input wire [31:0] i_ceiling,
	input wire [31:0] i_value,
	output wire o_ok
);
	// floor must not exceed ceiling
	wire order_ok = ($signed(i_floor) <= $signed(i_ceiling));
	// value inside the closed range
	wire range_ok = ($signed(i_value) >= $signed(i_floor)) && ($signed(i_value) <= $signed(i_ceiling));
	assign o_ok = order_ok && range_ok;
endmodule

// ### verif/ccp_config_parser_properties.sv
`timescale 1ns/10ps
// watches answer timing, store handshake and sticky settings
module ccp_config_parser_properties (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_cmd_valid,
	input wire logic [7:0] i_cmd_option,
	input wire logic [4:0] i_cmd_len,
	input wire logic i_store_done,
	input wire logic o_busy,
	input wire logic o_resp_valid,
	input wire logic [7:0] o_resp_status,
	input wire logic o_store_req,
	input wire logic o_no_chain_write,
	input wire logic o_leak_resilient_crypto_mode,
	input wire logic [15:0] o_fail_counter_limit,
	input wire logic o_file_rename_done,
	input wire logic o_value_setup_done
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	resp_pulse_a: assert property (o_resp_valid |=> !o_resp_valid)
		else $error("answer held longer than one cycle");
	answer_ends_busy_a: assert property (o_resp_valid |-> !o_busy && $past(o_busy))
		else $error("answer without a busy command");
	store_hold_a: assert property (o_store_req && !i_store_done |=> o_store_req)
		else $error("store request dropped early");
	store_ok_a: assert property (o_store_req && i_store_done |=> o_resp_valid && o_resp_status == 8'h00)
		else $error("no success answer after store");
	len_err_a: assert property (i_cmd_valid && !o_busy && i_cmd_option == 8'h0A && i_cmd_len != 5'h05
		|-> ##[1:40] (o_resp_valid && o_resp_status == 8'h7E)) else $error("bad length not refused");
	lrc_sticky_a: assert property (o_leak_resilient_crypto_mode |=> o_leak_resilient_crypto_mode)
		else $error("crypto mode switched back");
	done_sticky_a: assert property (o_value_setup_done |=> o_value_setup_done)
		else $error("one-time flag cleared");
	done_after_store_a: assert property ($rose(o_file_rename_done) |-> $past(i_store_done) && $past(o_store_req))
		else $error("rename flag set without store");
	cfg_at_store_a: assert property ($changed(o_no_chain_write) || $changed(o_fail_counter_limit)
		|-> $past(i_store_done)) else $error("setting changed outside store");
endmodule
bind ccp_config_parser ccp_config_parser_properties chk_u (.*);

// ### verif/ccp_store_model.sv
`timescale 1ns/10ps
// nonvolatile store: acknowledges a store request after a chosen wait
module ccp_store_model (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_req,
	input wire logic [3:0] i_wait,
	output logic o_done
);
	logic [3:0] cnt_reg; // cycles waited on the pending request
	always @(negedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_reg <= 4'h0;
			o_done <= 1'b0;
		end else if (i_req && !o_done && cnt_reg >= i_wait) begin
			o_done <= 1'b1;
		end else begin
			o_done <= 1'b0;
			cnt_reg <= i_req ? cnt_reg + 4'h1 : 4'h0;
		end
	end
endmodule

// ### verif/ccp_config_parser_tb.sv
`timescale 1ns/10ps
`include "ccp_regs.vh"
// drives configuration commands, checks answers and stored settings
module ccp_config_parser_tb;
	logic i_clk, i_resetn, i_cmd_valid, i_byte_valid, i_store_done, o_rename_two, o_rename_iso;
	logic [7:0] i_cmd_option, i_byte, o_resp_status, o_user_capability_5, o_user_capability_6;
	logic [7:0] o_app_rename_option_byte, d[20];
	logic [4:0] i_cmd_len, o_first_current_file_number, o_first_new_file_number;
	logic [4:0] o_second_current_file_number, o_second_new_file_number, o_value_file_number;
	logic [31:0] i_file_present, i_file_is_value, o_value_floor, o_value_ceiling, o_value_current;
	logic [31:0] seed = 32'h0000_f461;
	logic [15:0] o_app_iso_file_identifier, o_first_new_iso_identifier, o_second_new_iso_identifier;
	logic [15:0] o_fail_counter_limit, o_fail_counter_decrement, e16;
	logic [127:0] o_directory_name, e128;
	logic o_busy, o_resp_valid, o_store_req, o_no_chain_write, o_leak_resilient_crypto_mode;
	logic o_value_free_read, o_bounded_credit_enable, o_fail_counter_enable;
	logic o_app_rename_done, o_file_rename_done, o_value_setup_done;
	logic [3:0] st_wait; // store latency of the partner, varied per command
	logic [7:0] ops[7] = '{8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h07};
	int lens[7] = '{3, 9, 18, 4, 13, 0, 1};
	int n_fail, checks_done, cycles, k, lo, hi, vv;
	ccp_config_parser dut_u (.*);
	ccp_store_model store_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(o_store_req), .i_wait(st_wait),
		.o_done(i_store_done));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic fill();
		for (int i = 0; i < 20; i++) d[i] = rnd();
	endtask
	task automatic put(input int p, input logic [31:0] v);
		for (int i = 0; i < 4; i++) d[p + i] = v[8 * i +: 8];
	endtask
	// renaming length worked out from the option bits
	function automatic int fr_len_of(input logic [7:0] o);
		return 3 + (o[0] ? 2 : 0) + (o[1] ? 2 : 0) + ((o[1] && o[0]) ? 2 : 0);
	endfunction
	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one command: entered and left at a falling edge, bytes follow the start
	task automatic cmd(input logic [7:0] op, input int n, input logic [7:0] e);
		int t;
		void'(rnd());
		st_wait = {2'b00, seed[1:0]};
		i_cmd_valid = 1'b1;
		i_cmd_option = op;
		i_cmd_len = n[4:0];
		@(negedge i_clk);
		i_cmd_valid = 1'b0;
		for (t = 0; t < n; t++) begin
			i_byte_valid = 1'b1;
			i_byte = d[t];
			@(negedge i_clk);
		end
		i_byte_valid = 1'b0;
		t = 0;
		while (o_resp_valid !== 1'b1 && t < 60) begin
			@(posedge i_clk);
			#1;
			t++;
		end
		chk("resp_valid", 1'b1, o_resp_valid);
		chk("status", e, o_resp_status);
		chk("busy", 1'b0, o_busy);
		@(negedge i_clk);
	endtask
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	// cut a hang short
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			wrap_up();
		end
	end
	initial begin
		{i_resetn, i_cmd_valid, i_byte_valid, i_cmd_option, i_byte, i_cmd_len, st_wait} = '0;
		i_file_present = 32'h0000_00ff;
		i_file_is_value = 32'h0000_0008;
		repeat (20) @(negedge i_clk);
		i_resetn = 1'b1;
		chk("fc_en", 1'b1, o_fail_counter_enable);
		chk("fc_lim", `CCP_FC_LIMIT_DEF, o_fail_counter_limit);
		chk("fc_dec", `CCP_FC_DECR_DEF, o_fail_counter_decrement);
		// chained write disable, zero leaves it
		d[0] = 8'h00;
		d[1] = 8'h04;
		cmd(8'h04, 2, 8'h00);
		d[1] = 8'h00;
		cmd(8'h04, 2, 8'h00);
		chk("nochain", 1'b1, o_no_chain_write);
		$display("test secure messaging done");
		// permanent crypto mode and user bytes
		fill();
		d[4] = 8'h02;
		cmd(8'h05, 10, 8'h00);
		chk("cap5", d[8], o_user_capability_5);
		chk("cap6", d[9], o_user_capability_6);
		d[4] = 8'h00;
		cmd(8'h05, 10, 8'h00);
		chk("lrc", 1'b1, o_leak_resilient_crypto_mode);
		// wrong lengths and an unknown option
		for (k = 0; k < 7; k++) cmd(ops[k], lens[k], k == 6 ? 8'h9e : 8'h7e);
		$display("test capability and length done");
		// counter limit, zero refused, ignored on disable
		fill();
		d[0] = 8'h01;
		{d[2], d[1]} = 16'h0000;
		cmd(8'h0a, 5, 8'h9e);
		d[1] = d[7] | 8'h01;
		e16 = {d[2], d[1]};
		cmd(8'h0a, 5, 8'h00);
		chk("fc_dec", {d[4], d[3]}, o_fail_counter_decrement);
		{d[2], d[1], d[0]} = 24'h00_0000;
		cmd(8'h0a, 5, 8'h00);
		chk("fc_en", 1'b0, o_fail_counter_enable);
		chk("fc_lim", e16, o_fail_counter_limit);
		$display("test fail counter done");
		lo = $signed(rnd()) >>> 2;
		hi = lo + 1 + int'(rnd() & 32'h0fff_ffff);
		vv = lo + (hi - lo) / 2;
		{d[0], d[13]} = {8'h0c, 8'h03};
		put(1, hi);
		put(5, lo);
		put(9, vv);
		cmd(8'h09, 14, 8'hf0);
		d[0] = 8'h03;
		cmd(8'h09, 14, 8'h9e);
		put(1, lo);
		put(5, hi);
		put(9, hi + 1);
		cmd(8'h09, 14, 8'h9e);
		put(9, vv);
		cmd(8'h09, 14, 8'h00);
		chk("floor", lo[31:0], o_value_floor);
		chk("ceil", hi[31:0], o_value_ceiling);
		chk("value", vv[31:0], o_value_current);
		chk("vo", 3'h7, {o_value_file_number == 5'h03, o_value_free_read, o_bounded_credit_enable});
		chk("vdone", 1'b1, o_value_setup_done);
		cmd(8'h09, 14, 8'h9d);
		$display("test value file done");
		fill();
		{d[0], d[1], d[4], d[5], d[8]} = {8'h03, 8'h01, 8'h10, 8'h0c, 8'h20};
		cmd(8'h08, 9, 8'hf0);
		d[5] = 8'h02;
		cmd(8'h08, 5, 8'h7e);
		cmd(8'h08, fr_len_of(d[0]), 8'h00);
		chk("f1", {d[1][4:0], d[2][4:0]}, {o_first_current_file_number, o_first_new_file_number});
		chk("f2", {d[5][4:0], d[6][4:0]}, {o_second_current_file_number, o_second_new_file_number});
		chk("ids", {d[4], d[3], d[8], d[7]}, {o_first_new_iso_identifier, o_second_new_iso_identifier});
		chk("ren", 3'b111, {o_rename_two, o_rename_iso, o_file_rename_done});
		cmd(8'h08, 9, 8'h9d);
		fill();
		{d[0], d[17], d[18]} = {8'h80, 8'hff, 8'h3f};
		cmd(8'h06, 19, 8'h9e);
		d[0] = 8'h85;
		cmd(8'h06, 19, 8'h9e);
		d[18] = 8'h40;
		for (k = 6; k < 17; k++) d[k] = 8'h00;
		for (k = 0; k < 16; k++) e128[8 * k +: 8] = d[k + 1];
		cmd(8'h06, 19, 8'h00);
		chk("name", e128, o_directory_name);
		chk("fid", {d[18], d[17], d[0]}, {o_app_iso_file_identifier, o_app_rename_option_byte});
		chk("appdone", 1'b1, o_app_rename_done);
		cmd(8'h06, 17, 8'h9d);
		$display("test renaming done");
		// mid-run reset clears the one-time flags and restores defaults
		i_resetn = 1'b0;
		repeat (2) @(negedge i_clk);
		i_resetn = 1'b1;
		chk("fren_done", 1'b0, o_file_rename_done);
		chk("fc_lim", `CCP_FC_LIMIT_DEF, o_fail_counter_limit);
		// second pair follows first pair without identifiers
		fill();
		{d[0], d[1], d[3]} = {8'h02, 8'h01, 8'h02};
		cmd(8'h08, fr_len_of(d[0]), 8'h00);
		chk("f2b", {d[3][4:0], d[4][4:0]}, {o_second_current_file_number, o_second_new_file_number});
		chk("id1b", 16'h0000, o_first_new_iso_identifier);
		chk("renb", 3'b101, {o_rename_two, o_rename_iso, o_file_rename_done});
		$display("test reset and second renaming done");
		wrap_up();
	end
endmodule
